// ---- hdl/waf_map.svh ----
// register-free constants for the windowed averaging filter
`ifndef WAF_MAP_SVH
`define WAF_MAP_SVH
`define WAF_DEPTH_MIN 8'h01
`define WAF_DEPTH_MAX 8'hff
`define WAF_DEPTH_RST 8'h01
`define WAF_WIDTH_MIN 16'h0001
`define WAF_WIDTH_RST 16'hffff
`define WAF_CFG_SEL_CODE 4'h2
`endif

// ---- hdl/waf_pkg.sv ----
// types shared by the windowed averaging filter
package waf_pkg;
  typedef logic [1:0] waf_chan_t;
  typedef struct packed {
    logic [1:0] chan;
    logic signed [23:0] value;
  } waf_smp_s;
  typedef struct packed {
    logic [1:0] chan;
    logic signed [23:0] value;
    logic raw;
  } waf_out_s;
  typedef enum logic [1:0] {
    WAF_ST_IDLE = 2'b00,
    WAF_ST_CALC = 2'b01,
    WAF_ST_SEND = 2'b10
  } waf_st_e;
endpackage : waf_pkg

// ---- hdl/waf_filter.sv ----
// windowed averaging filter with per-channel depth and window settings
// Notes on behaviour
// (RULE_01) averaging depth per channel is 1..255 samples, averaged over fewer until that many are held
// (RULE_02) window width per channel in display counts, 1..65535
// (RULE_03) while filtering, output is mean of the most recent depth samples
// (RULE_04) averaging continues while each sample stays inside the window
// (RULE_05) a sample outside the window is output raw at once
// (RULE_06) once the signal settles a new window is set and averaging restarts
// (RULE_07) settings are held per channel, chosen by the configuration channel select
// (RULE_08) settled means next sample within width of the outlier; recentre and clear history
`timescale 1ns/1ps
`include "waf_map.svh"
module waf_filter
  import waf_pkg::*;
#(
  parameter int CHANS = 4,
  parameter int DEPTH_MAX = 255
)(
  input wire logic mclk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic cfg_we, // configuration write strobe
  input wire logic [3:0] cfg_code, // selection code middle digit, 2 selects averaging setup
  input wire waf_pkg::waf_chan_t cfg_chan, // channel the settings apply to
  input wire logic [7:0] sample_depth_setting, // samples to average
  input wire logic [15:0] window_width_setting, // window width in counts
  input wire waf_pkg::waf_smp_s in_data, // incoming sample
  input wire logic in_valid, // sample present
  output logic in_ready, // filter can take a sample
  output waf_pkg::waf_out_s out_data, // result, raw flag set on pass-through
  output logic out_valid, // result present
  input wire logic out_ready // downstream accepts
);
  import waf_pkg::*;

  logic [7:0] depth_r [CHANS];
  logic [15:0] width_r [CHANS];
  logic signed [23:0] hist_r [CHANS][DEPTH_MAX];
  logic [7:0] wp_r [CHANS];
  logic [7:0] fill_r [CHANS];
  logic signed [31:0] sum_r [CHANS];
  logic signed [23:0] ctr_r [CHANS];
  logic unstable_r [CHANS];
  logic cand_r [CHANS]; // a candidate centre is held, none after reset
  waf_st_e st_r;
  waf_smp_s cur_r;
  waf_out_s res_r;
  // two-entry output buffer
  waf_out_s buf_r [2];
  logic [1:0] cnt_r;
  logic rd_r;
  logic wr_r;
  logic [1:0] cnt_nxt;
  logic rd_nxt;
  waf_out_s head_nxt;

  // configuration per channel, out-of-range values clamped to the legal span
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      for (int i = 0; i < CHANS; i++)
      begin
        depth_r[i] <= `WAF_DEPTH_RST;
        width_r[i] <= `WAF_WIDTH_RST;
      end
    end
    else if (cfg_we && cfg_code == `WAF_CFG_SEL_CODE) // RULE_07
    begin
      depth_r[cfg_chan] <= (sample_depth_setting < `WAF_DEPTH_MIN) ? `WAF_DEPTH_MIN
                           : sample_depth_setting; // RULE_01
      width_r[cfg_chan] <= (window_width_setting < `WAF_WIDTH_MIN) ? `WAF_WIDTH_MIN
                           : window_width_setting; // RULE_02
    end
  end

  // absolute distance of a sample from a reference against the width; 25 bits so no overflow
  function automatic logic inside_win(input logic signed [23:0] a, input logic signed [23:0] b,
                                      input logic [15:0] w);
    logic signed [24:0] d;
    d = 25'(a) - 25'(b);
    if (d < 0)
      d = -d;
    return d <= 25'(w);
  endfunction : inside_win

  wire logic take = in_valid && in_ready;
  wire logic buf_full = (cnt_r == 2'd2);
  wire logic push = (st_r == WAF_ST_SEND) && !buf_full;
  wire logic pop = out_valid && out_ready;

  // sequencer: one sample in flight, stalls while the buffer is full
  always_ff @(posedge mclk)
  begin
    if (rst)
      st_r <= WAF_ST_IDLE;
    else
    begin
      unique case (st_r)
        WAF_ST_IDLE: if (take) st_r <= WAF_ST_CALC;
        WAF_ST_CALC: st_r <= WAF_ST_SEND;
        WAF_ST_SEND: if (push) st_r <= WAF_ST_IDLE;
        default: st_r <= WAF_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      cur_r <= '0;
    else if (take)
      cur_r <= in_data;
  end

  // window check and running sum; division once per sample is acceptable at this rate
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      res_r <= '0;
      for (int i = 0; i < CHANS; i++)
      begin
        wp_r[i] <= 8'h00;
        fill_r[i] <= 8'h00;
        sum_r[i] <= '0;
        ctr_r[i] <= '0;
        unstable_r[i] <= 1'b1;
        cand_r[i] <= 1'b0;
      end
    end
    else if (st_r == WAF_ST_CALC)
    begin
      automatic int c = int'(cur_r.chan);
      automatic logic [7:0] d = depth_r[c];
      automatic logic signed [31:0] s;
      automatic logic [7:0] f;
      res_r.chan <= cur_r.chan;
      if (unstable_r[c] || fill_r[c] == 8'h00)
      begin
        if (cand_r[c] && inside_win(cur_r.value, ctr_r[c], width_r[c]))
        begin
          // settled: recentre and restart history with this sample
          ctr_r[c] <= cur_r.value; // RULE_06 RULE_08
          unstable_r[c] <= 1'b0;
          cand_r[c] <= 1'b0;
          sum_r[c] <= 32'(cur_r.value);
          hist_r[c][0] <= cur_r.value;
          wp_r[c] <= (d == 8'h01) ? 8'h00 : 8'h01;
          fill_r[c] <= 8'h01;
          res_r.value <= cur_r.value;
          res_r.raw <= 1'b0;
        end
        else
        begin
          // no reference yet (reset) or too far from it: this sample becomes the candidate
          ctr_r[c] <= cur_r.value; // RULE_08
          cand_r[c] <= 1'b1;
          unstable_r[c] <= 1'b1;
          res_r.value <= cur_r.value; // RULE_05
          res_r.raw <= 1'b1;
        end
      end
      else if (!inside_win(cur_r.value, ctr_r[c], width_r[c]))
      begin
        // outlier: pass raw, remember it as the candidate centre
        unstable_r[c] <= 1'b1;
        cand_r[c] <= 1'b1;
        fill_r[c] <= 8'h00;
        ctr_r[c] <= cur_r.value;
        res_r.value <= cur_r.value; // RULE_05
        res_r.raw <= 1'b1;
      end
      else
      begin
        // inside: replace oldest once depth reached, else grow
        s = sum_r[c] + 32'(cur_r.value); // RULE_04
        f = fill_r[c];
        if (f >= d)
        begin
          s = s - 32'(hist_r[c][wp_r[c]]);
          f = d;
        end
        else
          f = f + 8'h01;
        hist_r[c][wp_r[c]] <= cur_r.value;
        wp_r[c] <= (wp_r[c] + 8'h01 >= d) ? 8'h00 : wp_r[c] + 8'h01;
        fill_r[c] <= f;
        sum_r[c] <= s;
        res_r.value <= 24'(s / $signed({24'h0, f})); // RULE_03 RULE_01
        res_r.raw <= 1'b0;
      end
    end
  end

  // next buffer state, so that the outputs can come straight from flops
  always_comb
  begin
    cnt_nxt = cnt_r + 2'(push) - 2'(pop);
    rd_nxt = pop ? ~rd_r : rd_r;
    head_nxt = (push && wr_r == rd_nxt) ? res_r : buf_r[rd_nxt]; // bypass when the pushed entry is next out
  end

  // output buffer pointers and storage
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_r <= 2'd0;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        buf_r[wr_r] <= res_r;
        wr_r <= ~wr_r;
      end
      if (pop)
        rd_r <= ~rd_r;
      cnt_r <= cnt_nxt;
    end
  end

  // registered in_ready handshake output
  always_ff @(posedge mclk)
  begin
    if (rst)
      in_ready <= 1'b0;
    else
      in_ready <= (st_r == WAF_ST_IDLE) && !take;
  end

  // registered head of the buffer; out_valid tracks a non-empty count
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      out_valid <= (cnt_nxt != 2'd0);
      out_data <= head_nxt;
    end
  end

  a_raw_passes: assert property (@(posedge mclk) disable iff (rst)
    (st_r == WAF_ST_CALC && !unstable_r[cur_r.chan] && fill_r[cur_r.chan] != 8'h00 &&
     !inside_win(cur_r.value, ctr_r[cur_r.chan], width_r[cur_r.chan]))
    |=> (res_r.raw && res_r.value == $past(cur_r.value))) // RULE_05
    else $error("outlier not passed raw");
  a_depth_legal: assert property (@(posedge mclk) disable iff (rst)
    depth_r[0] >= `WAF_DEPTH_MIN && width_r[0] >= `WAF_WIDTH_MIN) // RULE_01
    else $error("setting below minimum");
  a_buf_bound: assert property (@(posedge mclk) disable iff (rst) cnt_r <= 2'd2)
    else $error("buffer overflow");

  // settling has two steps: a sample near the candidate in calc, then a restarted history
  sequence s_settle_in;
    st_r == WAF_ST_CALC && unstable_r[cur_r.chan] && cand_r[cur_r.chan] &&
    inside_win(cur_r.value, ctr_r[cur_r.chan], width_r[cur_r.chan]);
  endsequence
  sequence s_restart_out;
    !res_r.raw && res_r.value == cur_r.value && fill_r[cur_r.chan] == 8'h01 &&
    !unstable_r[cur_r.chan] && ctr_r[cur_r.chan] == cur_r.value;
  endsequence
  a_settle_restart: assert property (@(posedge mclk) disable iff (rst) s_settle_in |=> s_restart_out) // RULE_06
    else $error("settled sample did not restart averaging");
  a_cand_raw: assert property (@(posedge mclk) disable iff (rst) // RULE_08
    (st_r == WAF_ST_CALC && unstable_r[cur_r.chan] && !cand_r[cur_r.chan]) |=> res_r.raw)
    else $error("unsettled sample not passed raw");
  a_busy_refused: assert property (@(posedge mclk) disable iff (rst) (st_r != WAF_ST_IDLE) |-> !in_ready)
    else $error("sample accepted while one is in flight");
  a_out_hold: assert property (@(posedge mclk) disable iff (rst) // result and valid held while the sink stalls
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
    else $error("result changed while stalled");
endmodule : waf_filter

// ---- sim/waf_src.sv ----
// upstream converter model feeding samples to the filter
`timescale 1ns/1ps
module waf_src (
  input wire logic mclk, // system clock
  input wire logic in_ready, // filter can take a sample
  output waf_pkg::waf_smp_s in_data, // sample
  output logic in_valid // sample present
);
  import waf_pkg::*;

  // idle until asked
  initial
  begin
    in_valid = 1'b0;
    in_data = '0;
  end

  // hold the sample until taken, then scramble the released bus
  task automatic send(input logic [1:0] ch, input logic [23:0] v);
    @(negedge mclk);
    in_data = '{chan: ch, value: v};
    in_valid = 1'b1;
    while (in_ready !== 1'b1)
      @(negedge mclk);
    @(negedge mclk);
    in_valid = 1'b0;
    in_data = ~in_data; // no stale sample left on the bus
    repeat (4) @(negedge mclk); // converter spaces samples apart
  endtask : send
endmodule : waf_src

// ---- sim/test_windowed_averaging_filter.sv ----
// self-checking bench for the windowed averaging filter
`timescale 1ns/1ps
module test_windowed_averaging_filter;
  import waf_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, cfg_we = 1'b0, out_ready = 1'b1;
  logic [3:0] cfg_code = 4'h2;
  waf_chan_t cfg_chan = 2'h0;
  logic [7:0] depth = 8'h01;
  logic [15:0] width = 16'hffff;
  waf_smp_s in_data;
  logic in_valid, in_ready, out_valid;
  waf_out_s out_data;
  waf_out_s exp_q[$];
  int n_errors = 0, total_checks = 0;

  always #4 mclk = ~mclk;

  waf_filter dut (.mclk(mclk), .rst(rst), .cfg_we(cfg_we), .cfg_code(cfg_code), .cfg_chan(cfg_chan),
    .sample_depth_setting(depth), .window_width_setting(width), .in_data(in_data), .in_valid(in_valid),
    .in_ready(in_ready), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
  waf_src src (.mclk(mclk), .in_ready(in_ready), .in_data(in_data), .in_valid(in_valid));

  task automatic chk(input logic [26:0] seen, input logic [26:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic cfg(input logic [3:0] code, input logic [1:0] ch, input logic [7:0] d, input logic [15:0] w);
    @(negedge mclk);
    {cfg_code, cfg_chan, depth, width, cfg_we} = {code, ch, d, w, 1'b1};
    @(negedge mclk);
    cfg_we = 1'b0;
  endtask : cfg

  task automatic put(input logic [1:0] ch, input logic [23:0] v, input logic r, input logic [23:0] e);
    exp_q.push_back('{chan: ch, value: e, raw: r});
    src.send(ch, v);
  endtask : put

  // every expected result must have come back in order
  task automatic drain;
    repeat (200)
      if (exp_q.size() != 0)
        @(negedge mclk);
    chk(27'(exp_q.size()), 27'h0);
  endtask : drain

  // score each result as the sink takes it; a surplus result meets an unknown
  always @(posedge mclk)
  begin
    if (out_valid === 1'b1 && out_ready === 1'b1)
      chk(out_data, exp_q.size() ? exp_q.pop_front() : 27'hx);
  end

  // averaging builds up to the full depth, then slides
  task automatic t_avg;
    cfg(4'h2, 2'h0, 8'h04, 16'h0064);
    put(2'h0, 24'h64, 1'b1, 24'h64);
    put(2'h0, 24'h68, 1'b0, 24'h68);
    put(2'h0, 24'h6c, 1'b0, 24'h6a);
    put(2'h0, 24'h70, 1'b0, 24'h6c);
    put(2'h0, 24'h74, 1'b0, 24'h6e);
    put(2'h0, 24'h78, 1'b0, 24'h72);
    drain();
  endtask : t_avg

  // outlier passes raw, then a fresh window and history
  task automatic t_outlier;
    put(2'h0, 24'h7d0, 1'b1, 24'h7d0);
    put(2'h0, 24'h7d2, 1'b0, 24'h7d2);
    put(2'h0, 24'h7d4, 1'b0, 24'h7d3);
    drain();
  endtask : t_outlier

  // wrong selection code ignored; narrowest window on its own channel
  task automatic t_chan;
    cfg(4'h3, 2'h1, 8'h02, 16'h0001);
    put(2'h1, 24'h32, 1'b1, 24'h32);
    put(2'h1, 24'h3c, 1'b0, 24'h3c);
    put(2'h1, 24'h46, 1'b0, 24'h46);
    cfg(4'h2, 2'h2, 8'h02, 16'h0001);
    put(2'h2, 24'ha, 1'b1, 24'ha);
    put(2'h2, 24'ha, 1'b0, 24'ha);
    put(2'h2, 24'hd, 1'b1, 24'hd);
    cfg(4'h2, 2'h3, 8'h00, 16'h0000);
    put(2'h3, 24'h10, 1'b1, 24'h10);
    put(2'h3, 24'h11, 1'b0, 24'h11);
    put(2'h3, 24'h12, 1'b0, 24'h12);
    put(2'h3, 24'h14, 1'b1, 24'h14);
    drain();
  endtask : t_chan

  // sink stalls long enough to fill the buffer; nothing may be lost
  task automatic t_stall;
    @(negedge mclk);
    out_ready = 1'b0;
    fork
      begin
        repeat (60) @(negedge mclk);
        out_ready = 1'b1;
      end
      for (int i = 0; i < 4; i++)
        put(2'h1, 24'h50 + 24'(i), 1'b0, 24'h50 + 24'(i));
    join
    drain();
  endtask : t_stall

  initial
  begin
    repeat (5) @(negedge mclk);
    chk({25'h0, in_ready, out_valid}, 27'h0);
    rst = 1'b0;
    repeat (2) @(negedge mclk);
    t_avg();
    t_outlier();
    t_chan();
    t_stall();
    test_done();
  end

  // cut a hang short
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    test_done();
  end
endmodule : test_windowed_averaging_filter
